// ### hw/dpcs_top.sv
// dpcs_top: staged and active per-lane path configuration with path states
// assumes: all control inputs are driven by management logic on core_clk
//
// Contract
// - selector zero marks lane unused, no path
// - unused lane ignores tag and override bit
// - unused lane always reports deactivated state
// - active set cannot be written by host
// - one active and at least one staged set
// - staged writes never touch hardware or active
// - apply copies staged to active, then commission
// - active set mirrors hardware only while its path is initializing or active; hw copy loads only on init and holds unused entries while deactivated
// - entry holds selector, lowest-lane tag, override bit
// - path resources initialize and release as group
// - each path controlled independently of others
// - path status reported identically on its lanes
// - tag equals lowest lane of the path
// - override set uses host settings, else module's
`timescale 1ns/1ns
`include "dpcs_defs.svh"

module dpcs_top #(
    parameter int LANES = `DPCS_LANES,
    parameter int NUM_STAGED = `DPCS_NUM_STAGED,
    parameter int INIT_CYCLES = `DPCS_INIT_CYCLES,
    parameter int SI_W = `DPCS_SI_W,
    parameter int SET_W = (NUM_STAGED > 1) ? $clog2(NUM_STAGED) : 1
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // staged set write
    input wire logic stg_wr,
    input wire logic [SET_W-1:0] stg_wr_set,
    input wire logic [`DPCS_TAG_W-1:0] stg_wr_lane,
    input wire logic [`DPCS_SEL_W-1:0] stg_wr_sel,
    input wire logic [`DPCS_TAG_W-1:0] stg_wr_tag,
    input wire logic stg_wr_ovr,
    // staged set readback
    input wire logic [SET_W-1:0] stg_rd_set,
    input wire logic [`DPCS_TAG_W-1:0] stg_rd_lane,
    output logic [`DPCS_SEL_W-1:0] stg_rd_sel,
    output logic [`DPCS_TAG_W-1:0] stg_rd_tag,
    output logic stg_rd_ovr,
    // provisioning: copy staged lanes into the active set
    input wire logic apply,
    input wire logic [SET_W-1:0] apply_set,
    input wire logic [LANES-1:0] apply_mask,
    // commissioning, one mask bit per lowest lane of a path
    input wire logic dp_init,
    input wire logic [LANES-1:0] dp_init_mask,
    input wire logic dp_deinit,
    input wire logic [LANES-1:0] dp_deinit_mask,
    // host signal settings per lane
    input wire logic [LANES-1:0][SI_W-1:0] host_si,
    // active set, read only
    output logic [LANES-1:0][`DPCS_SEL_W-1:0] act_sel,
    output logic [LANES-1:0][`DPCS_TAG_W-1:0] act_tag,
    output logic [LANES-1:0] act_ovr,
    // per-lane state
    output dpcs_pkg::dpcs_path_state_t [LANES-1:0] lane_state,
    // committed hardware configuration
    output logic [LANES-1:0][`DPCS_SEL_W-1:0] hw_sel,
    output logic [LANES-1:0][`DPCS_TAG_W-1:0] hw_tag,
    output logic [LANES-1:0][SI_W-1:0] si_eff
);
    import dpcs_pkg::*;

    localparam int NPATH = 1 << `DPCS_TAG_W;

    // ------------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------------
    initial begin
        if (LANES < 2 || LANES > NPATH) begin
            $error("dpcs_top: LANES out of range");
        end
        if (NUM_STAGED < 1) begin
            $error("dpcs_top: at least one staged set needed");
        end
        if (SET_W < 1 || (1 << SET_W) < NUM_STAGED) begin
            $error("dpcs_top: SET_W too narrow");
        end
    end

    localparam dpcs_lane_cfg_t CFG_DEFAULT = '{
        application_selector_field: `DPCS_DEFAULT_SEL,
        lowest_lane_tag: `DPCS_DEFAULT_TAG,
        override_bit: `DPCS_DEFAULT_OVR
    };
    localparam dpcs_lane_cfg_t CFG_UNUSED = '{
        application_selector_field: `DPCS_SEL_UNUSED,
        lowest_lane_tag: `DPCS_DEFAULT_TAG,
        override_bit: 1'b0
    };

    // storage: staged sets, active set, hardware copy, reported state
    dpcs_lane_cfg_t [NUM_STAGED-1:0][LANES-1:0] staged_r, staged_nxt;
    dpcs_lane_cfg_t [LANES-1:0] active_r, active_nxt;
    dpcs_lane_cfg_t [LANES-1:0] hw_r, hw_nxt;
    dpcs_path_state_t [LANES-1:0] lane_state_r, lane_state_nxt;
    dpcs_lane_cfg_t rd_r, rd_nxt;

    // per-path controls, padded to every tag value
    dpcs_path_state_t [NPATH-1:0] path_state;
    logic [NPATH-1:0] start_req;
    logic [NPATH-1:0] stop_req;
    logic [LANES-1:0] act_used;

    // ------------------------------------------------------------------------
    // path controllers, one per possible lowest lane
    // ------------------------------------------------------------------------
    generate
        for (genvar p = 0; p < NPATH; p++) begin : g_path
            if (p < LANES) begin : g_real
                // a path starts only from its lowest lane with a used entry
                assign start_req[p] = dp_init && dp_init_mask[p] && act_used[p]
                    && active_r[p].lowest_lane_tag == `DPCS_TAG_W'(p)
                    && path_state[p] == dpcs_st_deact;
                assign stop_req[p] = dp_deinit && dp_deinit_mask[p];
                dpcs_path_ctl #(
                    .INIT_CYCLES(INIT_CYCLES)
                ) u_path (
                    .core_clk(core_clk),
                    .srst(srst),
                    .ce(ce),
                    .start(start_req[p]),
                    .stop(stop_req[p]),
                    .state(path_state[p])
                );
            end else begin : g_none
                assign start_req[p] = 1'b0;
                assign stop_req[p] = 1'b0;
                assign path_state[p] = dpcs_st_deact;
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // per-lane logic: used flag and effective signal settings
    // ------------------------------------------------------------------------
    generate
        for (genvar l = 0; l < LANES; l++) begin : g_lane
            assign act_used[l] = active_r[l].application_selector_field != `DPCS_SEL_UNUSED;
            dpcs_si_select #(
                .SI_W(SI_W),
                .SI_DEFAULT(SI_W'(`DPCS_SI_DEFAULT))
            ) u_si (
                .core_clk(core_clk),
                .srst(srst),
                .ce(ce),
                .used(hw_r[l].application_selector_field != `DPCS_SEL_UNUSED),
                .ovr(hw_r[l].override_bit),
                .host_si(host_si[l]),
                .si_eff(si_eff[l])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // next values of the sets and of the reported state
    // ------------------------------------------------------------------------
    always_comb begin
        staged_nxt = staged_r;
        active_nxt = active_r;
        hw_nxt = hw_r;
        lane_state_nxt = lane_state_r;
        rd_nxt = rd_r;
        // staged write: stored only, nothing else moves
        if (stg_wr && int'(stg_wr_set) < NUM_STAGED && int'(stg_wr_lane) < LANES) begin
            staged_nxt[stg_wr_set][stg_wr_lane] = '{
                application_selector_field: stg_wr_sel,
                lowest_lane_tag: stg_wr_tag,
                override_bit: stg_wr_ovr
            };
        end
        if (int'(stg_rd_set) < NUM_STAGED && int'(stg_rd_lane) < LANES) begin
            rd_nxt = staged_r[stg_rd_set][stg_rd_lane];
        end else begin
            rd_nxt = CFG_UNUSED;
        end
        for (int l = 0; l < LANES; l++) begin
            // provisioning only on lanes whose path is deactivated
            if (apply && apply_mask[l] && int'(apply_set) < NUM_STAGED
                && (!act_used[l]
                    || path_state[active_r[l].lowest_lane_tag] == dpcs_st_deact)
                && !(act_used[l] && start_req[active_r[l].lowest_lane_tag])) begin
                active_nxt[l] = staged_r[apply_set][l];
            end
            // commissioning: the whole path takes its active entries at once
            if (act_used[l] && start_req[active_r[l].lowest_lane_tag]) begin
                hw_nxt[l] = active_r[l];
            end else if (stop_req[hw_r[l].lowest_lane_tag]
                && hw_r[l].application_selector_field != `DPCS_SEL_UNUSED) begin
                hw_nxt[l] = CFG_UNUSED;
            end
            // each lane shows the state of the path it belongs to
            if (act_used[l]) begin
                lane_state_nxt[l] = path_state[active_r[l].lowest_lane_tag];
            end else begin
                lane_state_nxt[l] = dpcs_st_deact;
            end
        end
    end

    // registers; the active set has no host write path at all
    always_ff @(posedge core_clk) begin
        if (srst) begin
            staged_r <= {(NUM_STAGED * LANES){CFG_DEFAULT}};
            active_r <= {LANES{CFG_DEFAULT}};
            hw_r <= {LANES{CFG_UNUSED}};
            lane_state_r <= '{default: dpcs_st_deact};
            rd_r <= CFG_UNUSED;
        end else if (ce) begin
            staged_r <= staged_nxt;
            active_r <= active_nxt;
            hw_r <= hw_nxt;
            lane_state_r <= lane_state_nxt;
            rd_r <= rd_nxt;
        end
    end

    // outputs straight from the registers
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            act_sel[l] = active_r[l].application_selector_field;
            act_tag[l] = active_r[l].lowest_lane_tag;
            act_ovr[l] = active_r[l].override_bit;
            hw_sel[l] = hw_r[l].application_selector_field;
            hw_tag[l] = hw_r[l].lowest_lane_tag;
        end
    end
    assign lane_state = lane_state_r;
    assign stg_rd_sel = rd_r.application_selector_field;
    assign stg_rd_tag = rd_r.lowest_lane_tag;
    assign stg_rd_ovr = rd_r.override_bit;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    generate
        for (genvar l = 0; l < LANES; l++) begin : g_chk
            property p_unused_deact;
                @(posedge core_clk) disable iff (srst)
                (ce && !act_used[l]) |=> lane_state_r[l] == dpcs_st_deact;
            endproperty
            a_unused_deact: assert property (p_unused_deact)
                else $error("unused lane not deactivated");
        end
    endgenerate

    property p_active_ro;
        @(posedge core_clk) disable iff (srst)
        !(ce && apply) |=> $stable(active_r);
    endproperty
    a_active_ro: assert property (p_active_ro) else $error("active set changed");

    property p_staged_only;
        @(posedge core_clk) disable iff (srst)
        (ce && stg_wr && !apply && start_req == '0 && stop_req == '0)
            |=> $stable(active_r) && $stable(hw_r);
    endproperty
    a_staged_only: assert property (p_staged_only) else $error("staged write leaked");

    property p_hw_commit;
        @(posedge core_clk) disable iff (srst)
        (ce && start_req[0]) |=> hw_r[0] == $past(active_r[0])
            ##1 (!$past(ce) || lane_state_r[0] != dpcs_st_deact);
    endproperty
    a_hw_commit: assert property (p_hw_commit) else $error("commit mismatch");

    property p_hw_quiet;
        @(posedge core_clk) disable iff (srst)
        !(ce && (start_req != '0 || stop_req != '0)) |=> $stable(hw_r);
    endproperty
    a_hw_quiet: assert property (p_hw_quiet) else $error("hardware changed unasked");

    property p_same_status;
        @(posedge core_clk) disable iff (srst)
        (ce && act_used[0] && act_used[1]
            && active_r[0].lowest_lane_tag == active_r[1].lowest_lane_tag)
            |=> lane_state_r[0] == lane_state_r[1];
    endproperty
    a_same_status: assert property (p_same_status) else $error("path lanes differ");

    property p_start_tag;
        @(posedge core_clk) disable iff (srst)
        (ce && start_req[LANES/2]) |=> hw_r[LANES/2].lowest_lane_tag == `DPCS_TAG_W'(LANES/2);
    endproperty
    a_start_tag: assert property (p_start_tag) else $error("path tag not lowest lane");

    property p_cov_apply;
        @(posedge core_clk) disable iff (srst)
        ce && apply && apply_mask != '0;
    endproperty
    c_cov_apply: cover property (p_cov_apply);

    property p_cov_commit;
        @(posedge core_clk) disable iff (srst)
        ce && start_req != '0;
    endproperty
    c_cov_commit: cover property (p_cov_commit);

    property p_cov_deinit;
        @(posedge core_clk) disable iff (srst)
        ce && dp_deinit && lane_state_r[0] == dpcs_st_act;
    endproperty
    c_cov_deinit: cover property (p_cov_deinit);

endmodule

// ### hw/dpcs_defs.svh
// dpcs_defs.svh: constants of the data path control set block
// assumes: included by the package and by every design file that needs a figure
`ifndef DPCS_DEFS_SVH
`define DPCS_DEFS_SVH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define DPCS_LANES 8
`define DPCS_NUM_STAGED 1
`define DPCS_SEL_W 4
`define DPCS_TAG_W 3
`define DPCS_SI_W 8

// ----------------------------------------------------------------------------
// field values and reset contents
// ----------------------------------------------------------------------------
`define DPCS_SEL_UNUSED 4'h0
`define DPCS_DEFAULT_SEL 4'h1
`define DPCS_DEFAULT_TAG 3'h0
`define DPCS_DEFAULT_OVR 1'b0
`define DPCS_SI_DEFAULT 8'h00

// ----------------------------------------------------------------------------
// timing: path initialization takes at least this long
// ----------------------------------------------------------------------------
`define DPCS_CLK_PERIOD_NS 50
`define DPCS_INIT_TIME_NS 2000
`define DPCS_INIT_CYCLES \
    ((`DPCS_INIT_TIME_NS + `DPCS_CLK_PERIOD_NS - 1) / `DPCS_CLK_PERIOD_NS)

`endif

// ### hw/dpcs_pkg.sv
// dpcs_pkg: types shared by the data path control set block
// assumes: dpcs_defs.svh is on the include path
`include "dpcs_defs.svh"

package dpcs_pkg;

    // ------------------------------------------------------------------------
    // reported state of a data path, copied onto each of its lanes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        dpcs_st_deact,
        dpcs_st_init,
        dpcs_st_act
    } dpcs_path_state_t;

    // ------------------------------------------------------------------------
    // one per-lane path configuration entry
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`DPCS_SEL_W-1:0] application_selector_field;
        logic [`DPCS_TAG_W-1:0] lowest_lane_tag;
        logic override_bit;
    } dpcs_lane_cfg_t;

endpackage

// ### hw/dpcs_path_ctl.sv
// dpcs_path_ctl: state of one data path, initialized and released as a group
// assumes: start and stop come from logic on core_clk, already qualified
`timescale 1ns/1ns
`include "dpcs_defs.svh"

module dpcs_path_ctl #(
    parameter int INIT_CYCLES = `DPCS_INIT_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // requests for this path only
    input wire logic start,
    input wire logic stop,
    // path state
    output dpcs_pkg::dpcs_path_state_t state
);
    import dpcs_pkg::*;

    localparam int CW = $clog2(INIT_CYCLES + 1);

    initial begin
        if (INIT_CYCLES < 1) begin
            $error("dpcs_path_ctl: INIT_CYCLES must be at least 1");
        end
    end

    dpcs_path_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    // next state: whole path moves together
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            dpcs_st_deact: begin
                if (start) begin
                    state_nxt = dpcs_st_init;
                    cnt_nxt = CW'(INIT_CYCLES - 1);
                end
            end
            dpcs_st_init: begin
                if (stop) begin
                    state_nxt = dpcs_st_deact;
                end else if (cnt_r == '0) begin
                    state_nxt = dpcs_st_act;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            dpcs_st_act: begin
                if (stop) begin
                    state_nxt = dpcs_st_deact;
                end
            end
            default: begin
                state_nxt = dpcs_st_deact;
            end
        endcase
    end

    // registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= dpcs_st_deact;
            cnt_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign state = state_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_init_done;
        @(posedge core_clk) disable iff (srst)
        (ce && state_r == dpcs_st_init && cnt_r == '0 && !stop) |=> state_r == dpcs_st_act;
    endproperty
    a_init_done: assert property (p_init_done) else $error("path did not finish init");

    property p_start_go;
        @(posedge core_clk) disable iff (srst)
        (ce && state_r == dpcs_st_deact && start) |=> (state_r == dpcs_st_init);
    endproperty
    a_start_go: assert property (p_start_go) else $error("path start ignored");

    property p_own_stop_only;
        @(posedge core_clk) disable iff (srst)
        (state_r == dpcs_st_act && !(ce && stop)) |=> state_r == dpcs_st_act;
    endproperty
    a_own_stop_only: assert property (p_own_stop_only) else $error("path left act");

    property p_reach_act;
        @(posedge core_clk) disable iff (srst)
        state_r == dpcs_st_init ##1 state_r == dpcs_st_act;
    endproperty
    c_reach_act: cover property (p_reach_act);

endmodule

// ### hw/dpcs_si_select.sv
// dpcs_si_select: effective signal settings of one lane
// assumes: used and ovr come from the committed hardware configuration
`timescale 1ns/1ns
`include "dpcs_defs.svh"

module dpcs_si_select #(
    parameter int SI_W = `DPCS_SI_W,
    parameter logic [SI_W-1:0] SI_DEFAULT = `DPCS_SI_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // committed lane setup
    input wire logic used,
    input wire logic ovr,
    input wire logic [SI_W-1:0] host_si,
    // settings applied to the lane
    output logic [SI_W-1:0] si_eff
);
    import dpcs_pkg::*;

    initial begin
        if (SI_W < 1) begin
            $error("dpcs_si_select: SI_W must be at least 1");
        end
    end

    logic [SI_W-1:0] si_r, si_nxt;

    // host settings only on a used lane with the override set
    always_comb begin
        if (used && ovr) begin
            si_nxt = host_si;
        end else begin
            si_nxt = SI_DEFAULT;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            si_r <= SI_DEFAULT;
        end else if (ce) begin
            si_r <= si_nxt;
        end
    end

    assign si_eff = si_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    property p_host_si;
        @(posedge core_clk) disable iff (srst)
        (ce && used && ovr) |=> si_r == $past(host_si);
    endproperty
    a_host_si: assert property (p_host_si) else $error("host settings not used");

    property p_module_si;
        @(posedge core_clk) disable iff (srst)
        (ce && !(used && ovr)) |=> si_r == SI_DEFAULT;
    endproperty
    a_module_si: assert property (p_module_si) else $error("module settings not used");

endmodule

// ### verif/dpcs_host_model.sv
// dpcs_host_model: host side of the lane settings, one fixed value per lane
// assumes: the device only reads these while a lane's override bit is set
`timescale 1ns/1ns

module dpcs_host_model #(
    parameter int LANES = 8,
    parameter int SI_W = 8
) (
    // settings toward the device
    output logic [LANES-1:0][SI_W-1:0] host_si
);
    // a distinct value on every lane, so a lane mix-up shows
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            host_si[l] = SI_W'(8'ha8 + l);
        end
    end
endmodule

// ### verif/dpcs_top_tb.sv
// dpcs_top_tb: staged writes, apply, commissioning and release of paths
// assumes: INIT_CYCLES set to 2 here, one staged set, eight lanes
`timescale 1ns/1ns

module dpcs_top_tb;
    import dpcs_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic core_clk = 0, srst = 1, ce = 1, stg_wr = 0, stg_wr_ovr = 0;
    logic apply = 0, dp_init = 0, dp_deinit = 0, stg_rd_ovr;
    logic [0:0] stg_wr_set = '0, stg_rd_set = '0, apply_set = '0;
    logic [2:0] stg_wr_lane = '0, stg_wr_tag = '0, stg_rd_lane = '0, stg_rd_tag;
    logic [3:0] stg_wr_sel = '0, stg_rd_sel;
    logic [7:0] apply_mask = '0, dp_init_mask = '0, dp_deinit_mask = '0, act_ovr;
    logic [7:0][7:0] host_si, si_eff;
    logic [7:0][3:0] act_sel, hw_sel;
    logic [7:0][2:0] act_tag, hw_tag;
    dpcs_path_state_t [7:0] lane_state;
    int miscompares = 0, n_tests = 0;

    always #25 core_clk = ~core_clk;

    dpcs_top #(.INIT_CYCLES(2)) u_dpcs_top (.core_clk(core_clk), .srst(srst), .ce(ce),
        .stg_wr(stg_wr), .stg_wr_set(stg_wr_set), .stg_wr_lane(stg_wr_lane),
        .stg_wr_sel(stg_wr_sel), .stg_wr_tag(stg_wr_tag), .stg_wr_ovr(stg_wr_ovr),
        .stg_rd_set(stg_rd_set), .stg_rd_lane(stg_rd_lane), .stg_rd_sel(stg_rd_sel),
        .stg_rd_tag(stg_rd_tag), .stg_rd_ovr(stg_rd_ovr), .apply(apply),
        .apply_set(apply_set), .apply_mask(apply_mask), .dp_init(dp_init),
        .dp_init_mask(dp_init_mask), .dp_deinit(dp_deinit), .dp_deinit_mask(dp_deinit_mask),
        .host_si(host_si), .act_sel(act_sel), .act_tag(act_tag), .act_ovr(act_ovr),
        .lane_state(lane_state), .hw_sel(hw_sel), .hw_tag(hw_tag), .si_eff(si_eff));

    dpcs_host_model u_dpcs_host_model (.host_si(host_si));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // settle after n edges
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // one staged entry, strobe left high for back to back use
    task automatic wr(input logic [2:0] l, input logic [3:0] s, input logic [2:0] t,
                      input logic o);
        @(posedge core_clk);
        stg_wr <= 1'b1;
        stg_wr_lane <= l;
        stg_wr_sel <= s;
        stg_wr_tag <= t;
        stg_wr_ovr <= o;
    endtask
    // k picks apply, init, release in that bit order
    task automatic req(input logic [2:0] k, input logic [7:0] m);
        @(posedge core_clk);
        {apply, dp_init, dp_deinit} <= k;
        apply_mask <= m;
        dp_init_mask <= m;
        dp_deinit_mask <= m;
    endtask
    // drop all strobes, settle after the edge that takes the request
    task automatic idle();
        @(posedge core_clk);
        {stg_wr, apply, dp_init, dp_deinit} <= '0;
        #1;
    endtask
    // expected state on lanes lo..hi
    task automatic st(input int lo, input int hi, input dpcs_path_state_t e);
        for (int l = lo; l <= hi; l++) chk("lane_state", lane_state[l], e);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        step(2);
        for (int l = 0; l < 8; l++) begin
            chk("act_sel", act_sel[l], 4'h1);
            chk("hw_sel", hw_sel[l], 4'h0);
        end
        st(0, 7, dpcs_st_deact);
        done("reset");
        // path at lanes 0..2, lane 3 unused with stray tag, path at lanes 4..7
        for (int l = 0; l < 8; l++)
            wr(3'(l), (l < 3) ? 4'h3 : (l == 3) ? 4'h0 : 4'h2,
               (l == 3) ? 3'h5 : (l < 3) ? 3'h0 : 3'h4, l == 3 || l == 5);
        idle();
        step(2);
        for (int l = 0; l < 8; l++) chk("act_sel", act_sel[l], 4'h1);
        @(posedge core_clk);
        stg_rd_lane <= 3'h3;
        step(1);
        chk("stg_rd", {stg_rd_sel, stg_rd_tag, stg_rd_ovr}, {4'h0, 3'h5, 1'b1});
        done("staged");
        req(3'b100, 8'hff);
        idle();
        chk("act_sel", act_sel[3], 4'h0);
        chk("act_tag", act_tag[6], 3'h4);
        chk("hw_sel", hw_sel[4], 4'h0);
        chk("act_ovr", act_ovr[5], 1'b1);
        step(1);
        st(0, 7, dpcs_st_deact);
        done("apply");
        // bit 3 unused lane and bit 5 non-lowest lane must be ignored
        req(3'b010, 8'h38);
        idle();
        for (int l = 0; l < 8; l++) chk("hw_sel", hw_sel[l], (l > 3) ? 4'h2 : 4'h0);
        step(1);
        st(4, 7, dpcs_st_init);
        st(0, 3, dpcs_st_deact);
        chk("si_eff", si_eff[5], 8'had);
        chk("si_eff", si_eff[4], 8'h00);
        chk("si_eff", si_eff[3], 8'h00);
        chk("hw_tag", hw_tag[7], 3'h4);
        step(3);
        st(4, 7, dpcs_st_act);
        done("commission");
        req(3'b010, 8'h01);
        idle();
        step(1);
        st(0, 2, dpcs_st_init);
        st(3, 3, dpcs_st_deact);
        st(4, 7, dpcs_st_act);
        // apply on an active path is refused
        wr(3'h4, 4'h5, 3'h4, 1'b0);
        idle();
        req(3'b100, 8'hf0);
        idle();
        chk("act_sel", act_sel[4], 4'h2);
        done("independent");
        req(3'b001, 8'h10);
        idle();
        chk("hw_sel", hw_sel[4], 4'h0);
        step(1);
        st(4, 7, dpcs_st_deact);
        st(0, 2, dpcs_st_act);
        req(3'b100, 8'hf0);
        idle();
        chk("act_sel", act_sel[4], 4'h5);
        chk("hw_sel", hw_sel[4], 4'h0);
        done("release");
        // a release strobe while the enable is low must not be taken
        @(posedge core_clk);
        ce <= 1'b0;
        req(3'b001, 8'h01);
        idle();
        step(1);
        chk("hw_sel", hw_sel[0], 4'h3);
        st(0, 2, dpcs_st_act);
        @(posedge core_clk);
        ce <= 1'b1;
        step(1);
        chk("hw_sel", hw_sel[0], 4'h3);
        done("freeze");
        end_of_test();
    end
endmodule
